/* File: cbbce_cfg.svh */
// Constants of the branch, bit-clear and AND execution block.
`ifndef CBBCE_CFG_SVH
`define CBBCE_CFG_SVH

`define CBBCE_REG_INSTR   8'h00
`define CBBCE_REG_PC      8'h04
`define CBBCE_REG_STATUS  8'h08
`define CBBCE_REG_WORK    8'h0C
`define CBBCE_REG_BANK    8'h10
`define CBBCE_REG_EXEC    8'h14
`define CBBCE_REG_MADDR   8'h18
`define CBBCE_REG_MDATA   8'h1C

`define CBBCE_OPC_BRC     8'hE2
`define CBBCE_OPC_BRN     8'hE6
`define CBBCE_OPC_BCLR    4'h9
`define CBBCE_OPC_ANDW    6'h05

`define CBBCE_F_BIT_HI    11
`define CBBCE_F_BIT_LO    9
`define CBBCE_F_D         9
`define CBBCE_F_A         8
`define CBBCE_F_SIGN      7

`define CBBCE_ST_C        0
`define CBBCE_ST_Z        2
`define CBBCE_ST_N        4
`define CBBCE_ST_MASK     8'h1F

`define CBBCE_EX_BUSY     0
`define CBBCE_EX_NOP      1

`define CBBCE_ACC_SPLIT   8'h80
`define CBBCE_ACC_LO_BANK 4'h0
`define CBBCE_ACC_HI_BANK 4'hF
`define CBBCE_BIT_ONE     8'h01
`define CBBCE_DMEM_AW     12
`define CBBCE_PC_W        21
`define CBBCE_PC_STEP     2
`define CBBCE_RES_MSB     7

`endif

/* File: cbbce_pkg.sv */
// Types shared by the execution block and its helpers.
package cbbce_pkg;

    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } cbbce_phase_t;

    typedef enum logic [2:0] {
        OP_NOP  = 3'b000,
        OP_BRC  = 3'b001,
        OP_BRN  = 3'b010,
        OP_BCLR = 3'b011,
        OP_ANDW = 3'b100
    } cbbce_op_t;

endpackage : cbbce_pkg

/* File: cbbce_core_if.sv */
// Signals between the executor, its phase sequencer and its data memory.
`timescale 1ns/1ps
`include "cbbce_cfg.svh"
interface cbbce_core_if;
    import cbbce_pkg::*;
    logic [`CBBCE_DMEM_AW-1:0] addr;
    logic                      we;
    logic [7:0]                wdata;
    logic [7:0]                rdata;
    logic                      start;
    logic                      flush;
    logic                      active;
    logic                      nop;
    cbbce_phase_t              phase;

    modport core (output addr, output we, output wdata, output start, output flush,
                  input rdata, input active, input nop, input phase);
    modport mem  (input addr, input we, input wdata, output rdata);
    modport seq  (input start, input flush, output active, output nop, output phase);
endinterface : cbbce_core_if

/* File: cbbce_phase_seq.sv */
// Four-phase instruction cycle sequencer with an optional flush cycle.
`timescale 1ns/1ps
`include "cbbce_cfg.svh"
module cbbce_phase_seq (
    input wire logic   clk_i,
    input wire logic   rst_i,
    cbbce_core_if.seq  sq
);
    import cbbce_pkg::*;

    logic         active_r;
    logic         nop_r;
    cbbce_phase_t phase_r;

    assign sq.active = active_r;
    assign sq.nop    = nop_r;
    assign sq.phase  = phase_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            active_r <= 1'b0;
            nop_r    <= 1'b0;
            phase_r  <= PH_Q1;
        end
        else if (!active_r)
        begin
            if (sq.start)
            begin
                active_r <= 1'b1;
                nop_r    <= 1'b0;
                phase_r  <= PH_Q1;
            end
        end
        else
        begin
            unique case (phase_r)
                PH_Q1: phase_r <= PH_Q2;
                PH_Q2: phase_r <= PH_Q3;
                PH_Q3: phase_r <= PH_Q4;
                PH_Q4:
                begin
                    phase_r <= PH_Q1;
                    // A taken branch adds one whole cycle of no operation.
                    if (sq.flush && !nop_r)
                    begin
                        nop_r <= 1'b1;
                    end
                    else
                    begin
                        active_r <= 1'b0;
                        nop_r    <= 1'b0;
                    end
                end
            endcase
        end
    end
endmodule : cbbce_phase_seq

/* File: cbbce_dmem.sv */
// Byte-wide data memory with registered read data.
`timescale 1ns/1ps
`include "cbbce_cfg.svh"
module cbbce_dmem #(
    parameter int AW = `CBBCE_DMEM_AW
) (
    input wire logic   clk_i,
    cbbce_core_if.mem  mp
);
    logic [7:0] mem_q [2**AW];
    logic [7:0] rdata_r;

    assign mp.rdata = rdata_r;

    // Reading during a write returns the old byte.
    always_ff @(posedge clk_i)
    begin
        if (mp.we)
        begin
            mem_q[mp.addr] <= mp.wdata;
        end
        rdata_r <= mem_q[mp.addr];
    end
endmodule : cbbce_dmem

/* File: cbbce_exec.sv */
// Executor for carry and negative branches, bit clear and AND with file register.
//
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "cbbce_cfg.svh"
module cbbce_exec #(
    parameter int PC_W = `CBBCE_PC_W
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);
    import cbbce_pkg::*;

    localparam int AW = `CBBCE_DMEM_AW;

    cbbce_core_if cif ();

    cbbce_phase_seq u_seq (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sq    (cif.seq)
    );

    cbbce_dmem #(
        .AW (AW)
    ) u_mem (
        .clk_i (clk_i),
        .mp    (cif.mem)
    );

    logic [15:0]     instr_r;
    logic [PC_W-1:0] pc_r;
    logic [7:0]      status_r;
    logic [7:0]      working_register_r;
    logic [3:0]      bank_select_register_r;
    logic [AW-1:0]   maddr_r;
    cbbce_op_t       op_r;
    logic            taken_r;
    logic [7:0]      result_r;
    logic            ack_r;
    logic [31:0]     dat_r;
    logic            pend_r;

    logic [7:0]      off;
    logic            req;
    logic            is_mdata;
    logic            rd_take;
    logic            wr_take;
    logic            mrd_take;
    logic            run;
    logic            d_bit;
    logic [2:0]      bit_sel;

    // Byte-lane merge of a bus write into a register image.
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return res;
    endfunction : wmerge

    function automatic cbbce_op_t decode_op(input logic [15:0] w);
        if (w[15:8] == `CBBCE_OPC_BRC)
        begin
            return OP_BRC;
        end
        if (w[15:8] == `CBBCE_OPC_BRN)
        begin
            return OP_BRN;
        end
        if (w[15:12] == `CBBCE_OPC_BCLR)
        begin
            return OP_BCLR;
        end
        if (w[15:10] == `CBBCE_OPC_ANDW)
        begin
            return OP_ANDW;
        end
        return OP_NOP;
    endfunction : decode_op

    // Full data address of the file operand of an instruction word.
    function automatic logic [AW-1:0] file_addr(input logic [15:0] w,
                                                input logic [3:0]  bank_sel);
        logic [3:0] bank;
        bank = bank_sel;
        if (!w[`CBBCE_F_A])
        begin
            bank = (w[7:0] < `CBBCE_ACC_SPLIT) ? `CBBCE_ACC_LO_BANK
                                                : `CBBCE_ACC_HI_BANK;
        end
        return AW'({bank, w[7:0]});
    endfunction : file_addr

    assign off      = {wb_adr_i[7:2], 2'b00};
    assign req      = wb_cyc_i & wb_stb_i & ~ack_r;
    assign is_mdata = (off == `CBBCE_REG_MDATA);
    // Register reads are served at once; writes and memory reads wait for idle.
    assign rd_take  = req & ~wb_we_i & ~is_mdata;
    assign wr_take  = req & wb_we_i & ~cif.active;
    assign mrd_take = req & ~wb_we_i & is_mdata & ~cif.active & ~pend_r;
    // Phase work is suppressed during the flush cycle.
    assign run      = cif.active & ~cif.nop;
    assign d_bit    = instr_r[`CBBCE_F_D];
    assign bit_sel  = instr_r[`CBBCE_F_BIT_HI:`CBBCE_F_BIT_LO];

    assign cif.start = wr_take & (off == `CBBCE_REG_INSTR);
    assign cif.flush = run & (cif.phase == PH_Q4) & taken_r;

    always_comb
    begin
        cif.addr  = maddr_r;
        cif.we    = 1'b0;
        cif.wdata = wb_dat_i[7:0];
        if (cif.active)
        begin
            cif.addr  = file_addr(instr_r, bank_select_register_r);
            cif.wdata = result_r;
            cif.we    = run & (cif.phase == PH_Q4) &
                        ((op_r == OP_BCLR) | ((op_r == OP_ANDW) & d_bit));
        end
        else if (wr_take && is_mdata && wb_sel_i[0])
        begin
            cif.we = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r  <= 1'b0;
            pend_r <= 1'b0;
            dat_r  <= '0;
        end
        else
        begin
            ack_r  <= rd_take | wr_take | pend_r;
            pend_r <= mrd_take;
            if (pend_r)
            begin
                dat_r <= {24'h000000, cif.rdata};
            end
            else if (rd_take)
            begin
                unique case (off)
                    `CBBCE_REG_INSTR:  dat_r <= {16'h0000, instr_r};
                    `CBBCE_REG_PC:     dat_r <= 32'(pc_r);
                    `CBBCE_REG_STATUS: dat_r <= {24'h000000, status_r};
                    `CBBCE_REG_WORK:   dat_r <= {24'h000000, working_register_r};
                    `CBBCE_REG_BANK:   dat_r <= {28'h0000000, bank_select_register_r};
                    `CBBCE_REG_EXEC:   dat_r <= {30'h00000000, cif.nop, cif.active};
                    `CBBCE_REG_MADDR:  dat_r <= 32'(maddr_r);
                    default:           dat_r <= '0;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            instr_r <= '0;
            maddr_r <= '0;
            bank_select_register_r <= '0;
        end
        else if (wr_take)
        begin
            if (off == `CBBCE_REG_INSTR)
            begin
                instr_r <= 16'(wmerge(32'(instr_r), wb_dat_i, wb_sel_i));
            end
            if (off == `CBBCE_REG_MADDR)
            begin
                maddr_r <= AW'(wmerge(32'(maddr_r), wb_dat_i, wb_sel_i));
            end
            if (off == `CBBCE_REG_BANK)
            begin
                bank_select_register_r <= 4'(wmerge(32'(bank_select_register_r), wb_dat_i,
                                                    wb_sel_i));
            end
        end
    end

    // Decode in Q1, evaluate the condition and the data result in Q3.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            op_r     <= OP_NOP;
            taken_r  <= 1'b0;
            result_r <= '0;
        end
        else if (run && cif.phase == PH_Q1)
        begin
            op_r    <= decode_op(instr_r);
            taken_r <= 1'b0;
        end
        else if (run && cif.phase == PH_Q3)
        begin
            unique case (op_r)
                OP_BRC:  taken_r <= status_r[`CBBCE_ST_C];
                OP_BRN:  taken_r <= status_r[`CBBCE_ST_N];
                default: taken_r <= 1'b0;
            endcase
            if (op_r == OP_BCLR)
            begin
                result_r <= cif.rdata & ~(`CBBCE_BIT_ONE << bit_sel);
            end
            else
            begin
                result_r <= working_register_r & cif.rdata;
            end
        end
    end

    // The counter steps one word in Q1 and takes the branch target in Q4.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pc_r <= '0;
        end
        else if (wr_take && off == `CBBCE_REG_PC)
        begin
            pc_r <= PC_W'(wmerge(32'(pc_r), wb_dat_i, wb_sel_i));
        end
        else if (run && cif.phase == PH_Q1)
        begin
            pc_r <= pc_r + PC_W'(`CBBCE_PC_STEP);
        end
        else if (run && cif.phase == PH_Q4 && taken_r)
        begin
            // The offset sits in the low byte and is doubled to a byte distance.
            pc_r <= pc_r + {{(PC_W-9){instr_r[`CBBCE_F_SIGN]}},
                            instr_r[7:0], 1'b0};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            working_register_r <= '0;
        end
        else if (wr_take && off == `CBBCE_REG_WORK)
        begin
            working_register_r <= 8'(wmerge(32'(working_register_r), wb_dat_i, wb_sel_i));
        end
        else if (run && cif.phase == PH_Q4 && op_r == OP_ANDW && !d_bit)
        begin
            working_register_r <= result_r;
        end
    end

    // Only the AND changes flags; branches and bit clear leave them alone.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            status_r <= '0;
        end
        else if (wr_take && off == `CBBCE_REG_STATUS)
        begin
            status_r <= 8'(wmerge(32'(status_r), wb_dat_i, wb_sel_i)) & `CBBCE_ST_MASK;
        end
        else if (run && cif.phase == PH_Q4 && op_r == OP_ANDW)
        begin
            status_r[`CBBCE_ST_N] <= result_r[`CBBCE_RES_MSB];
            status_r[`CBBCE_ST_Z] <= (result_r == '0);
        end
    end
endmodule : cbbce_exec

/* File: cbbce_exec_sva.sv */
// Bus timing checks on the ports of the branch, bit-clear and AND executor.
`timescale 1ns/1ps
module cbbce_exec_sva #(
    parameter int PC_W = 21
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence new_req;
        $rose(wb_cyc_i && wb_stb_i);
    endsequence

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stayed high for two cycles");
    ack_cause_a: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i && $past(wb_stb_i))
        else $error("ack without a pending request");
    reset_quiet_a: assert property ($fell(rst_i) |-> !wb_ack_o && wb_dat_o == 32'h0)
        else $error("bus outputs not cleared by reset");
    data_hold_a: assert property (!(wb_ack_o && !wb_we_i) && !$fell(rst_i) |-> $stable(wb_dat_o))
        else $error("read data moved without a read answer");
    unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h20 |-> wb_dat_o == 32'h0)
        else $error("unmapped read returned nonzero data");
    reg_read_a: assert property (new_req ##0 (!wb_we_i && wb_adr_i[7:2] != 6'h07) |=> wb_ack_o)
        else $error("register read not answered in one cycle");
    mem_read_a: assert property (new_req ##0 (!wb_we_i && wb_adr_i[7:2] == 6'h07) |=> !wb_ack_o ##[1:10] wb_ack_o)
        else $error("memory read answered at a wrong time");
    write_wait_a: assert property (new_req ##0 wb_we_i |-> ##[1:10] wb_ack_o)
        else $error("write not answered in time");

    cover property (new_req ##0 (wb_we_i && wb_adr_i == 8'h00));
    cover property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h1C);
    cover property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h20);
endmodule : cbbce_exec_sva

bind cbbce_exec cbbce_exec_sva #(.PC_W(PC_W)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

/* File: test_cond_branch_bit_clear_exec.sv */
// Self-checking bench of the branch, bit-clear and AND executor.
`timescale 1ns/1ps
module test_cond_branch_bit_clear_exec;
    logic        clk_i   = 1'b0;
    logic        rst_i   = 1'b1;
    logic        wb_cyc  = 1'b0;
    logic        wb_stb  = 1'b0;
    logic        wb_we   = 1'b0;
    logic [7:0]  wb_adr  = 8'h00;
    logic [3:0]  wb_sel  = 4'hF;
    logic [31:0] wb_dat  = 32'h0;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic [31:0] rd_d;
    int          lat;
    int          base;
    int          err_count = 0;
    int          checked   = 0;

    cbbce_exec dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));

    initial forever #10 clk_i = ~clk_i;

    task automatic final_report();
        if (err_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    // One classic cycle; lat counts the wait states before ack.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dat <= d;
        lat = 0;
        @(posedge clk_i);
        while (wb_ack !== 1'b1)
        begin
            lat++;
            @(posedge clk_i);
        end
        rd_d = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd_d, e);
    endtask : rc

    task automatic mw(input logic [11:0] m, input logic [7:0] v);
        bus(1'b1, 8'h18, 32'(m));
        bus(1'b1, 8'h1C, 32'(v));
    endtask : mw

    task automatic mc(input logic [11:0] m, input logic [7:0] e);
        bus(1'b1, 8'h18, 32'(m));
        rc(8'h1C, 32'(e));
    endtask : mc

    // The trailing write is held off until the instruction has finished.
    task automatic ex(input logic [15:0] i);
        bus(1'b1, 8'h00, 32'(i));
        bus(1'b1, 8'h24, 32'h0);
    endtask : ex

    task automatic br(input logic [15:0] i, input logic [4:0] st, input logic [31:0] pc,
                      input int tk);
        bus(1'b1, 8'h04, 32'h100);
        bus(1'b1, 8'h08, 32'(st));
        ex(i);
        chk(32'(lat), 32'(base + 4 * tk));
        rc(8'h04, pc);
        rc(8'h08, 32'(st));
    endtask : br

    initial
    begin
        #400000;
        err_count++;
        final_report();
    end

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // The data memory has no reset, so the byte behind the window is cleared first.
        bus(1'b1, 8'h1C, 32'h0);
        for (int a = 0; a <= 32; a += 4)
            rc(8'(a), 32'h0);
        ex(16'h0000);
        base = lat;
        br(16'hE205, 5'h01, 32'h10C, 1);
        br(16'hE205, 5'h10, 32'h102, 0);
        br(16'hE280, 5'h1F, 32'h002, 1);
        br(16'hE67F, 5'h10, 32'h200, 1);
        br(16'hE67F, 5'h01, 32'h102, 0);
        mw(12'h010, 8'hC7);
        mw(12'h310, 8'hC7);
        mw(12'hF90, 8'hC7);
        bus(1'b1, 8'h10, 32'h3);
        bus(1'b1, 8'h08, 32'h1F);
        ex(16'h9E10);
        mc(12'h010, 8'h47);
        mc(12'h310, 8'hC7);
        ex(16'h9110);
        mc(12'h310, 8'hC6);
        mc(12'h010, 8'h47);
        ex(16'h9490);
        mc(12'hF90, 8'hC3);
        rc(8'h08, 32'h1F);
        mw(12'h020, 8'hC2);
        bus(1'b1, 8'h0C, 32'h17);
        bus(1'b1, 8'h08, 32'h15);
        ex(16'h1420);
        rc(8'h0C, 32'h02);
        mc(12'h020, 8'hC2);
        rc(8'h08, 32'h01);
        bus(1'b1, 8'h0C, 32'h80);
        ex(16'h1620);
        mc(12'h020, 8'h80);
        rc(8'h0C, 32'h80);
        rc(8'h08, 32'h11);
        bus(1'b1, 8'h0C, 32'h01);
        ex(16'h1420);
        rc(8'h0C, 32'h00);
        rc(8'h08, 32'h05);
        final_report();
    end
endmodule : test_cond_branch_bit_clear_exec
